// File: shared/three_port_regs.svh
// Register indices, field widths, reset values and bus codes of the parallel ports
`ifndef THREE_PORT_REGS_SVH
`define THREE_PORT_REGS_SVH

// Line counts
`define WIDE_PORT_LINES    8
`define NARROW_PORT_LINES  4

// Register indices; byte address is four times the index
`define IDX_FIRST_DATA     3'h0
`define IDX_SECOND_DATA    3'h1
`define IDX_NARROW_DATA    3'h2
`define IDX_FIRST_DIR      3'h4
`define IDX_SECOND_DIR     3'h5
`define IDX_NARROW_DIR     3'h6

// Address field layout
`define INDEX_LSB          2
`define INDEX_MSB          4
`define ADDR_WIDTH_DEFAULT 8

// Reset values
`define DIR_RESET_BIT      1'b0
`define SYNC_RESET_BIT     1'b0

// Bus answer codes and widths
`define DATA_WIDTH         32
`define STRB_WIDTH         4
`define RESP_OKAY          2'h0
`define RESP_DECERR        2'h3

`endif

// File: shared/three_port_pkg.sv
// Types shared by the parallel port files
package three_port_pkg;

  // Decoded register selection
  typedef struct packed {
    logic       hit;
    logic [2:0] index;
  } reg_sel_s;

  // Captured write request
  typedef struct packed {
    logic       held;
    reg_sel_s   sel;
  } wr_addr_s;

  typedef struct packed {
    logic       held;
    logic       lane0;
    logic [7:0] value;
  } wr_data_s;

  // Bus channel states
  typedef enum logic [0:0] {
    WR_COLLECT,
    WR_RESPOND
  } wr_state_e;

  typedef enum logic [0:0] {
    RD_IDLE,
    RD_RESPOND
  } rd_state_e;

endpackage : three_port_pkg

// File: rtl/io_line_port.sv
// One bidirectional port: output latch, direction bits and pin synchroniser
`timescale 1ns/100ps
`include "three_port_regs.svh"
module io_line_port
  import three_port_pkg::*;
#(
  parameter int WIDTH = `WIDE_PORT_LINES
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Register access
  input  wire logic             latch_we,
  input  wire logic             dir_we,
  input  wire logic [WIDTH-1:0] wr_value,
  output logic      [WIDTH-1:0] data_view,
  output logic      [WIDTH-1:0] dir_view,
  // Pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe
);

  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] latch_nxt;
  logic [WIDTH-1:0] dir_r;
  logic [WIDTH-1:0] dir_nxt;
  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync1_nxt;
  logic [WIDTH-1:0] sync2_r;
  logic [WIDTH-1:0] sync2_nxt;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Next values
  always_comb begin
    latch_nxt = latch_we ? wr_value : latch_r;
    dir_nxt   = dir_we ? wr_value : dir_r;
    sync1_nxt = pin_in;
    sync2_nxt = sync1_r;
    out_nxt   = latch_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data latch keeps its contents through reset
  always_ff @(posedge clock) begin
    latch_r <= latch_nxt;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_r   <= {WIDTH{`DIR_RESET_BIT}};
      sync1_r <= {WIDTH{`SYNC_RESET_BIT}};
      sync2_r <= {WIDTH{`SYNC_RESET_BIT}};
      out_r   <= {WIDTH{`SYNC_RESET_BIT}};
    end else begin
      dir_r   <= dir_nxt;
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      out_r   <= out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-line read source and drive
  for (genvar i = 0; i < WIDTH; i++) begin : line_g
    assign data_view[i] = dir_r[i] ? latch_r[i] : sync2_r[i];
    assign pin_oe[i]    = dir_r[i];
  end

  assign dir_view = dir_r;
  assign pin_out  = out_r;

endmodule : io_line_port

// File: rtl/three_port_parallel_io.sv
// Three bidirectional parallel ports behind an AXI4-Lite register slave
//
// Functional notes
// - Twenty lines as two eight-line ports and one four-line port, each line set as input or output.
// - The first port's data register sits at index zero and its direction register at index four.
// - The second port's data register sits at index one and its direction register at index five.
// - The narrow port's data register sits at index two and its direction register at index six.
// - Any reset clears every direction bit, making all pins inputs, and leaves the data latches alone.
// - A line drives its pin while its direction bit is one and is a high-impedance input otherwise.
// - Direction registers are writable and read back the last value written, or zero after reset.
// - Reading data for a line set as output returns its output latch, not the pin.
// - Writing data for a line set as input updates only the latch and leaves the pin undriven.
// - Writing data for a line set as output updates the latch and drives the new value on the pin.
// - Reading data for a line set as input returns the level present on the pin.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "three_port_regs.svh"
module three_port_parallel_io
  import three_port_pkg::*;
#(
  parameter int ADDR_WIDTH   = `ADDR_WIDTH_DEFAULT,
  parameter int WIDE_LINES   = `WIDE_PORT_LINES,
  parameter int NARROW_LINES = `NARROW_PORT_LINES
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,

  // AXI4-Lite write address
  input  wire logic [ADDR_WIDTH-1:0]  awaddr,
  input  wire logic [2:0]             awprot,
  input  wire logic                   awvalid,
  output logic                        awready,

  // AXI4-Lite write data
  input  wire logic [`DATA_WIDTH-1:0] wdata,
  input  wire logic [`STRB_WIDTH-1:0] wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,

  // AXI4-Lite write response
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,

  // AXI4-Lite read address
  input  wire logic [ADDR_WIDTH-1:0]  araddr,
  input  wire logic [2:0]             arprot,
  input  wire logic                   arvalid,
  output logic                        arready,

  // AXI4-Lite read data
  output logic [`DATA_WIDTH-1:0]      rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,

  // First wide port pins
  input  wire logic [WIDE_LINES-1:0]  first_pin_in,
  output logic [WIDE_LINES-1:0]       first_pin_out,
  output logic [WIDE_LINES-1:0]       first_pin_oe,

  // Second wide port pins
  input  wire logic [WIDE_LINES-1:0]  second_pin_in,
  output logic [WIDE_LINES-1:0]       second_pin_out,
  output logic [WIDE_LINES-1:0]       second_pin_oe,

  // Narrow port pins
  input  wire logic [NARROW_LINES-1:0] narrow_pin_in,
  output logic [NARROW_LINES-1:0]      narrow_pin_out,
  output logic [NARROW_LINES-1:0]      narrow_pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic reg_sel_s decode_addr(input logic [ADDR_WIDTH-1:0] addr);
    reg_sel_s sel;
    sel.index = addr[`INDEX_MSB:`INDEX_LSB];
    sel.hit   = 1'b0;
    if ((addr >> (`INDEX_MSB + 1)) == '0) begin
      case (sel.index)
        `IDX_FIRST_DATA,
        `IDX_FIRST_DIR:   sel.hit = 1'b1;
        `IDX_SECOND_DATA,
        `IDX_SECOND_DIR:  sel.hit = 1'b1;
        `IDX_NARROW_DATA,
        `IDX_NARROW_DIR:  sel.hit = 1'b1;
        default:          sel.hit = 1'b0;
      endcase
    end
    return sel;
  endfunction : decode_addr

  // Answer code for a decoded access
  function automatic logic [1:0] answer_code(input reg_sel_s sel);
    return sel.hit ? `RESP_OKAY : `RESP_DECERR;
  endfunction : answer_code

  ////////////////////////////////////////////////////////////////////////////
  // Port register views
  logic [WIDE_LINES-1:0]   first_data_view;
  logic [WIDE_LINES-1:0]   first_dir_view;
  logic [WIDE_LINES-1:0]   second_data_view;
  logic [WIDE_LINES-1:0]   second_dir_view;
  logic [NARROW_LINES-1:0] narrow_data_view;
  logic [NARROW_LINES-1:0] narrow_dir_view;

  // Write strobes
  logic                    do_write;
  logic                    first_latch_we;
  logic                    first_dir_we;
  logic                    second_latch_we;
  logic                    second_dir_we;
  logic                    narrow_latch_we;
  logic                    narrow_dir_we;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel state
  wr_state_e               wr_state_r;
  wr_state_e               wr_state_nxt;
  wr_addr_s                wa_r;
  wr_addr_s                wa_nxt;
  wr_data_s                wd_r;
  wr_data_s                wd_nxt;
  logic [1:0]              bresp_r;
  logic [1:0]              bresp_nxt;

  always_comb begin
    wr_state_nxt = wr_state_r;
    wa_nxt       = wa_r;
    wd_nxt       = wd_r;
    bresp_nxt    = bresp_r;
    do_write     = 1'b0;
    case (wr_state_r)
      WR_COLLECT: begin
        if (awvalid && !wa_r.held) begin
          wa_nxt.held = 1'b1;
          wa_nxt.sel  = decode_addr(awaddr);
        end
        if (wvalid && !wd_r.held) begin
          wd_nxt.held  = 1'b1;
          wd_nxt.lane0 = wstrb[0];
          wd_nxt.value = wdata[7:0];
        end
        if (wa_r.held && wd_r.held) begin
          do_write     = wa_r.sel.hit && wd_r.lane0;
          bresp_nxt    = answer_code(wa_r.sel);
          wa_nxt.held  = 1'b0;
          wd_nxt.held  = 1'b0;
          wr_state_nxt = WR_RESPOND;
        end
      end
      WR_RESPOND: begin
        if (bready) begin
          wr_state_nxt = WR_COLLECT;
        end
      end
      default: begin
        wr_state_nxt = WR_COLLECT;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_r <= WR_COLLECT;
      wa_r       <= '0;
      wd_r       <= '0;
      bresp_r    <= `RESP_OKAY;
    end else begin
      wr_state_r <= wr_state_nxt;
      wa_r       <= wa_nxt;
      wd_r       <= wd_nxt;
      bresp_r    <= bresp_nxt;
    end
  end

  assign awready = (wr_state_r == WR_COLLECT) && !wa_r.held;
  assign wready  = (wr_state_r == WR_COLLECT) && !wd_r.held;
  assign bvalid  = (wr_state_r == WR_RESPOND);
  assign bresp   = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes per register
  always_comb begin
    first_latch_we  = do_write && (wa_r.sel.index == `IDX_FIRST_DATA);
    first_dir_we    = do_write && (wa_r.sel.index == `IDX_FIRST_DIR);
    second_latch_we = do_write && (wa_r.sel.index == `IDX_SECOND_DATA);
    second_dir_we   = do_write && (wa_r.sel.index == `IDX_SECOND_DIR);
    narrow_latch_we = do_write && (wa_r.sel.index == `IDX_NARROW_DATA);
    narrow_dir_we   = do_write && (wa_r.sel.index == `IDX_NARROW_DIR);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel state
  rd_state_e               rd_state_r;
  rd_state_e               rd_state_nxt;
  logic [`DATA_WIDTH-1:0]  rdata_r;
  logic [`DATA_WIDTH-1:0]  rdata_nxt;
  logic [1:0]              rresp_r;
  logic [1:0]              rresp_nxt;
  logic [`DATA_WIDTH-1:0]  read_word;
  reg_sel_s                rd_sel;

  // Register read mux, upper bits zero
  always_comb begin
    rd_sel    = decode_addr(araddr);
    read_word = '0;
    case (rd_sel.index)
      `IDX_FIRST_DATA:  read_word[WIDE_LINES-1:0]   = first_data_view;
      `IDX_SECOND_DATA: read_word[WIDE_LINES-1:0]   = second_data_view;
      `IDX_NARROW_DATA: read_word[NARROW_LINES-1:0] = narrow_data_view;
      `IDX_FIRST_DIR:   read_word[WIDE_LINES-1:0]   = first_dir_view;
      `IDX_SECOND_DIR:  read_word[WIDE_LINES-1:0]   = second_dir_view;
      `IDX_NARROW_DIR:  read_word[NARROW_LINES-1:0] = narrow_dir_view;
      default:          read_word = '0;
    endcase
    if (!rd_sel.hit) begin
      read_word = '0;
    end
  end

  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (arvalid) begin
          rdata_nxt    = read_word;
          rresp_nxt    = answer_code(rd_sel);
          rd_state_nxt = RD_RESPOND;
        end
      end
      RD_RESPOND: begin
        if (rready) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: begin
        rd_state_nxt = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_r <= RD_IDLE;
      rdata_r    <= '0;
      rresp_r    <= `RESP_OKAY;
    end else begin
      rd_state_r <= rd_state_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  assign arready = (rd_state_r == RD_IDLE);
  assign rvalid  = (rd_state_r == RD_RESPOND);
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // The three ports, twenty lines in all
  io_line_port #(
    .WIDTH     (WIDE_LINES)
  ) first_port (
    .clock     (clock),
    .rst_n     (rst_n),
    .latch_we  (first_latch_we),
    .dir_we    (first_dir_we),
    .wr_value  (wd_r.value[WIDE_LINES-1:0]),
    .data_view (first_data_view),
    .dir_view  (first_dir_view),
    .pin_in    (first_pin_in),
    .pin_out   (first_pin_out),
    .pin_oe    (first_pin_oe)
  );

  io_line_port #(
    .WIDTH     (WIDE_LINES)
  ) second_port (
    .clock     (clock),
    .rst_n     (rst_n),
    .latch_we  (second_latch_we),
    .dir_we    (second_dir_we),
    .wr_value  (wd_r.value[WIDE_LINES-1:0]),
    .data_view (second_data_view),
    .dir_view  (second_dir_view),
    .pin_in    (second_pin_in),
    .pin_out   (second_pin_out),
    .pin_oe    (second_pin_oe)
  );

  // Upper data bits dropped for the narrow port
  io_line_port #(
    .WIDTH     (NARROW_LINES)
  ) narrow_port (
    .clock     (clock),
    .rst_n     (rst_n),
    .latch_we  (narrow_latch_we),
    .dir_we    (narrow_dir_we),
    .wr_value  (wd_r.value[NARROW_LINES-1:0]),
    .data_view (narrow_data_view),
    .dir_view  (narrow_dir_view),
    .pin_in    (narrow_pin_in),
    .pin_out   (narrow_pin_out),
    .pin_oe    (narrow_pin_oe)
  );

endmodule : three_port_parallel_io

// File: testbench/three_port_monitor.sv
// Port-level checks of the parallel port block
`timescale 1ns/100ps
`include "three_port_regs.svh"
module three_port_monitor
  import three_port_pkg::*;
#(
  parameter int ADDR_WIDTH   = `ADDR_WIDTH_DEFAULT,
  parameter int WIDE_LINES   = `WIDE_PORT_LINES,
  parameter int NARROW_LINES = `NARROW_PORT_LINES
) (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rst_n,
  // Bus handshakes
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic [1:0]              bresp,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic [`DATA_WIDTH-1:0]  rdata,
  input wire logic [1:0]              rresp,
  input wire logic                    rvalid,
  input wire logic                    rready,
  // Pin enables
  input wire logic [WIDE_LINES-1:0]   first_pin_oe,
  input wire logic [WIDE_LINES-1:0]   second_pin_oe,
  input wire logic [NARROW_LINES-1:0] narrow_pin_oe
);
  logic [2*WIDE_LINES+NARROW_LINES-1:0] oe_all;
  assign oe_all = {first_pin_oe, second_pin_oe, narrow_pin_oe};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  a_oe_reset: assert property ($rose(rst_n) |-> oe_all == '0)
    else $error("enables not clear after reset");
  a_oe_moves: assert property ($changed(oe_all) |-> $rose(bvalid))
    else $error("enable moved without a write");
  a_wr_latency: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer timing wrong");
  a_wr_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  a_wr_refuse: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while answer pending");
  a_wr_reopen: assert property (bvalid && bready |=> awready && wready)
    else $error("write channel not reopened");
  a_rd_latency: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer timing wrong");
  a_rd_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  a_rd_upper_zero: assert property (rvalid |-> rdata[31:8] == '0)
    else $error("read upper bits not zero");
  a_decerr_zero: assert property (rvalid && rresp == `RESP_DECERR |-> rdata == '0)
    else $error("unmapped read data not zero");
endmodule : three_port_monitor

bind three_port_parallel_io three_port_monitor #(
  .ADDR_WIDTH(ADDR_WIDTH), .WIDE_LINES(WIDE_LINES), .NARROW_LINES(NARROW_LINES)
) three_port_monitor_inst (
  .clock(clock), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .first_pin_oe(first_pin_oe), .second_pin_oe(second_pin_oe), .narrow_pin_oe(narrow_pin_oe)
);

// File: testbench/pin_partner.sv
// Far-side circuit on one port's pins
`timescale 1ns/100ps
module pin_partner #(
  parameter int WIDTH = 8
) (
  // Design side
  input  wire logic [WIDTH-1:0] pin_out,
  input  wire logic [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] pin_in,
  // Level of the outside circuit
  input  wire logic [WIDTH-1:0] ext_level
);
  // Wire level per line
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
    end
  end
endmodule : pin_partner

// File: testbench/three_port_parallel_io_tb.sv
// Self-checking bench for the parallel port block
`timescale 1ns/100ps
`include "three_port_regs.svh"
module three_port_parallel_io_tb
  import three_port_pkg::*;
;
  logic        clock, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  first_pin_in, first_pin_out, first_pin_oe, second_pin_in, second_pin_out, second_pin_oe;
  logic [3:0]  narrow_pin_in, narrow_pin_out, narrow_pin_oe;
  logic [7:0]  ext_v [3];
  int          errors, n_checks;
  logic [7:0]  data_addr [3] = '{8'(`IDX_FIRST_DATA) << 2, 8'(`IDX_SECOND_DATA) << 2, 8'(`IDX_NARROW_DATA) << 2};
  logic [7:0]  dir_addr [3]  = '{8'(`IDX_FIRST_DIR) << 2, 8'(`IDX_SECOND_DIR) << 2, 8'(`IDX_NARROW_DIR) << 2};
  logic [7:0]  mask [3]      = '{8'hFF, 8'hFF, 8'h0F};

  three_port_parallel_io three_port_parallel_io_inst (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .first_pin_in(first_pin_in), .first_pin_out(first_pin_out), .first_pin_oe(first_pin_oe),
    .second_pin_in(second_pin_in), .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe),
    .narrow_pin_in(narrow_pin_in), .narrow_pin_out(narrow_pin_out), .narrow_pin_oe(narrow_pin_oe)
  );
  pin_partner #(.WIDTH(8)) first_side (.pin_out(first_pin_out), .pin_oe(first_pin_oe),
    .pin_in(first_pin_in), .ext_level(ext_v[0]));
  pin_partner #(.WIDTH(8)) second_side (.pin_out(second_pin_out), .pin_oe(second_pin_oe),
    .pin_in(second_pin_in), .ext_level(ext_v[1]));
  pin_partner #(.WIDTH(4)) narrow_side (.pin_out(narrow_pin_out), .pin_oe(narrow_pin_oe),
    .pin_in(narrow_pin_in), .ext_level(ext_v[2][3:0]));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [7:0] oe_of(input int i);
    return (i == 0) ? first_pin_oe : (i == 1) ? second_pin_oe : {4'h0, narrow_pin_oe};
  endfunction : oe_of

  function automatic logic [7:0] out_of(input int i);
    return (i == 0) ? first_pin_out : (i == 1) ? second_pin_out : {4'h0, narrow_pin_out};
  endfunction : out_of

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
      if (bvalid && !bready) begin
        bready <= 1'b1;
      end
    end while (!(bvalid && bready) && n < 40);
    if (!(bvalid && bready)) begin
      errors++;
      final_report();
    end
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid && !rready) begin
        rready <= 1'b1;
      end
    end while (!(rvalid && rready) && n < 40);
    if (!(rvalid && rready)) begin
      errors++;
      final_report();
    end
    rready <= 1'b0;
    check("rresp", {30'h0, er}, {30'h0, rresp});
    check("rdata", ed, rdata);
  endtask : axi_read

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awprot, arprot} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    ext_v = '{8'h3C, 8'hC3, 8'h09};
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      axi_read(dir_addr[i], 32'h0, `RESP_OKAY);
      axi_read(data_addr[i], {24'h0, ext_v[i] & mask[i]}, `RESP_OKAY);
      axi_write(data_addr[i], 32'hA5, `RESP_OKAY);
      check("oe input", 32'h0, {24'h0, oe_of(i)});
      axi_read(data_addr[i], {24'h0, ext_v[i] & mask[i]}, `RESP_OKAY);
      axi_write(dir_addr[i], 32'h0F, `RESP_OKAY);
      check("oe", {24'h0, 8'h0F & mask[i]}, {24'h0, oe_of(i)});
      check("pin out", {24'h0, 8'hA5 & mask[i]}, {24'h0, out_of(i)});
      axi_read(data_addr[i], {24'h0, (8'h05 | (ext_v[i] & 8'hF0)) & mask[i]}, `RESP_OKAY);
      axi_write(dir_addr[i], 32'hFFFF_FFFF, `RESP_OKAY);
      axi_read(dir_addr[i], {24'h0, mask[i]}, `RESP_OKAY);
      axi_read(data_addr[i], {24'h0, 8'hA5 & mask[i]}, `RESP_OKAY);
    end
    // Write with the low byte lane off leaves the latch alone
    wstrb <= 4'h0;
    axi_write(data_addr[0], 32'h5A, `RESP_OKAY);
    wstrb <= 4'hF;
    check("masked write", 32'hA5, {24'h0, out_of(0)});
    axi_read(data_addr[0], 32'hA5, `RESP_OKAY);
    axi_read(8'h0C, 32'h0, `RESP_DECERR);
    axi_write(8'h1C, 32'hFF, `RESP_DECERR);
    rst_n <= 1'b0;
    ext_v <= '{8'h81, 8'h18, 8'h06};
    repeat (2) @(posedge clock);
    check("oe in reset", 32'h0, {12'h0, first_pin_oe, second_pin_oe, narrow_pin_oe});
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // Pin change one edge before the read is still behind the synchroniser
    ext_v[0] <= 8'h7E;
    axi_read(data_addr[0], 32'h81, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      axi_read(dir_addr[i], 32'h0, `RESP_OKAY);
      axi_read(data_addr[i], {24'h0, ext_v[i] & mask[i]}, `RESP_OKAY);
      axi_write(dir_addr[i], 32'hFF, `RESP_OKAY);
      check("kept latch", {24'h0, 8'hA5 & mask[i]}, {24'h0, out_of(i)});
    end
    final_report();
  end
endmodule : three_port_parallel_io_tb
